// ### mcr_pkg.sv
package mcr_pkg;
    localparam int CLK_HZ = 250_000_000;
    localparam int BAUD = 19200;
    localparam int BIT_CYC = CLK_HZ / BAUD;
    localparam int RAMP_STEP_NS = 2441;
    localparam int RAMP_STEP_CYC = RAMP_STEP_NS * 250 / 1000;
    localparam logic [5:0] IDX_SPEED = 6'h00;
    localparam logic [5:0] IDX_DRIVE = 6'h02;
    localparam logic [5:0] IDX_REGEN = 6'h03;
    localparam logic [5:0] IDX_RISE = 6'h04;
    localparam logic [5:0] IDX_FALL = 6'h05;
    localparam logic [5:0] IDX_UV_OFF = 6'h06;
    localparam logic [5:0] IDX_UV_ON = 6'h07;
    localparam logic [5:0] IDX_OV_ON = 6'h08;
    localparam logic [5:0] IDX_OV_OFF = 6'h09;
    localparam logic [5:0] IDX_HEATSINK = 6'h0A;
    localparam logic [5:0] IDX_BOARD_T = 6'h0B;
    localparam logic [5:0] IDX_SUPPLY = 6'h10;
    localparam logic [5:0] IDX_SPD_IN = 6'h11;
    localparam logic [5:0] IDX_LOAD = 6'h12;
    localparam logic [5:0] IDX_PERIOD = 6'h14;
    localparam logic [5:0] IDX_PULSE = 6'h15;
    localparam logic [5:0] IDX_IR_GAIN = 6'h20;
    localparam logic [5:0] IDX_VMAX = 6'h21;
    localparam logic [5:0] IDX_KNOB_LO = 6'h22;
    localparam logic [5:0] IDX_KNOB_HI = 6'h23;
    localparam logic [5:0] IDX_STATE = 6'h30;
    localparam logic [5:0] IDX_HOLD = 6'h31;
    localparam logic [5:0] IDX_PERSIST1 = 6'h32;
    localparam logic [5:0] IDX_PERSIST2 = 6'h33;
    localparam logic [5:0] IDX_SETUP1 = 6'h34;
    localparam logic [5:0] IDX_SETUP2 = 6'h35;
    localparam logic [5:0] IDX_NODE = 6'h3C;
    localparam logic [5:0] IDX_TRIM = 6'h3D;
    localparam logic [5:0] IDX_FW_REV = 6'h3E;
    localparam logic [5:0] IDX_HW_REV = 6'h3F;
    localparam logic [11:0] OV_ON_RESET = 12'hA28;
    localparam logic [6:0] NODE_RESET = 7'h00;
    localparam logic [11:0] OV_OFF_MAX = 12'hA8D;
    localparam int CAP_AMPS = 200;
    localparam int CAP_LSB_UA = 54500;
    localparam logic [11:0] CAP_CODE = 12'(CAP_AMPS * 1000000 / CAP_LSB_UA);
    localparam logic [6:0] DUTY_TOP_PCT = 7'h61;
    localparam logic [6:0] DUTY_DIV = 7'h64;
    localparam int HOLD_SPEED = 0;
    localparam int HOLD_DRIVE = 1;
    localparam int HOLD_REGEN = 2;
    localparam int HOLD_RISE = 3;
    localparam logic [6:0] CRC_MASK = 7'h7F;

    typedef enum logic [2:0] {
        MCR_P_ADDR = 3'b000,
        MCR_P_CMD = 3'b001,
        MCR_P_D1 = 3'b010,
        MCR_P_D2 = 3'b011,
        MCR_P_CRC = 3'b100
    } mcr_phase_t;

    typedef struct packed {
        logic [11:0] speed_adc;
        logic [11:0] drive_knob;
        logic [11:0] regen_knob;
        logic [11:0] rise_knob;
        logic [11:0] heatsink;
        logic [11:0] board_temp;
        logic [11:0] supply;
        logic [11:0] load_cur;
        logic [11:0] period;
        logic [11:0] pulse_w;
        logic [11:0] state;
        logic [11:0] fw_rev;
        logic [11:0] hw_rev;
    } mcr_meas_t;

    typedef struct packed {
        logic [11:0] rise;
        logic [11:0] fall;
        logic [11:0] uv_off;
        logic [11:0] uv_on;
        logic [11:0] ov_on;
        logic [11:0] ov_off;
        logic [11:0] ir_gain;
        logic [11:0] vmax;
        logic [11:0] knob_lo;
        logic [11:0] knob_hi;
        logic [11:0] setup1;
        logic [11:0] setup2;
        logic [11:0] trim;
    } mcr_cfg_t;

    typedef struct packed {
        logic valid;
        logic [5:0] idx;
        logic [11:0] data;
    } mcr_restore_t;
endpackage : mcr_pkg

// ### mcr_register_bank.sv
`timescale 1ns/1ps
module mcr_register_bank #(
    parameter int BIT_CYCLES = mcr_pkg::BIT_CYC
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic uart_rx,
    output logic uart_tx,
    input wire mcr_pkg::mcr_meas_t meas,
    input wire logic cur_limit_hit,
    input wire mcr_pkg::mcr_restore_t restore,
    output logic [11:0] duty_out,
    output logic [11:0] drive_cap_eff,
    output logic [11:0] regen_cap_eff,
    output mcr_pkg::mcr_cfg_t settings,
    output logic save_strobe,
    output logic [23:0] save_mask
);

    localparam logic [15:0] BIT_LEN = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] HALF_BIT = 16'(BIT_CYCLES / 2);
    localparam logic [9:0] STEP_LEN = 10'(mcr_pkg::RAMP_STEP_CYC - 1);

    function automatic logic is_rw(input logic [5:0] idx);
        is_rw = (idx <= mcr_pkg::IDX_OV_OFF && idx != 6'h01)
            || (idx >= mcr_pkg::IDX_IR_GAIN && idx <= mcr_pkg::IDX_KNOB_HI)
            || (idx >= mcr_pkg::IDX_HOLD && idx <= mcr_pkg::IDX_SETUP2)
            || idx == mcr_pkg::IDX_NODE || idx == mcr_pkg::IDX_TRIM;
    endfunction : is_rw

    function automatic logic [6:0] check_of(input logic [7:0] a,
        input logic [7:0] b, input logic [7:0] c);
        logic [7:0] s;
        s = a + b + c;
        check_of = s[6:0] & mcr_pkg::CRC_MASK;
    endfunction : check_of

    function automatic logic [11:0] clamp12(input logic [11:0] v,
        input logic [11:0] lim);
        clamp12 = (v > lim) ? lim : v;
    endfunction : clamp12

    function automatic logic [23:0] reply_of(input logic [7:0] c,
        input logic [11:0] v);
        logic [7:0] b1;
        logic [7:0] b2;
        b1 = {3'b000, v[11:7]};
        b2 = {1'b0, v[6:0]};
        reply_of = {b1, b2, 1'b0, check_of(c, b1, b2)};
    endfunction : reply_of

    logic [11:0] bank [0:63];
    logic rx_s1;
    logic rx_s2;
    logic rx_busy;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bits;
    logic [8:0] tx_sh;
    logic [23:0] tx_q;
    logic [1:0] tx_n;
    mcr_pkg::mcr_phase_t phase;
    logic [7:0] cmd;
    logic [7:0] d1;
    logic [7:0] d2;
    logic wr_pulse;
    logic [5:0] wr_idx;
    logic [11:0] wr_val;
    logic [11:0] rd_val;
    logic [11:0] last_spd;
    logic [11:0] last_drive;
    logic [11:0] last_regen;
    logic [11:0] last_rise;
    logic spd_track;
    logic [9:0] step_pre;
    logic [11:0] step_cnt;
    logic [6:0] node_id;
    logic [18:0] duty_prod;
    logic [11:0] duty_base;

    assign node_id = bank[mcr_pkg::IDX_NODE][6:0];

    ////////////////////////////////////////////////////////////////////////
    // Receive line: synchroniser and byte deframer

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
        end
        else if (clk_en)
        begin
            rx_s1 <= uart_rx;
            rx_s2 <= rx_s1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_busy <= 1'b0;
            rx_cnt <= 16'h0000;
            rx_bit <= 4'h0;
            rx_sh <= 8'h00;
            rx_valid <= 1'b0;
            rx_byte <= 8'h00;
        end
        else if (clk_en)
        begin
            rx_valid <= 1'b0;
            if (!rx_busy)
            begin
                if (!rx_s2)
                begin
                    rx_busy <= 1'b1;
                    rx_cnt <= HALF_BIT;
                    rx_bit <= 4'h0;
                end
            end
            else if (rx_cnt != 16'h0000)
                rx_cnt <= rx_cnt - 16'h0001;
            else
            begin
                rx_cnt <= BIT_LEN;
                rx_bit <= rx_bit + 4'h1;
                if (rx_bit == 4'h0 && rx_s2)
                    rx_busy <= 1'b0;
                else if (rx_bit == 4'h9)
                begin
                    rx_busy <= 1'b0;
                    rx_valid <= rx_s2;
                    rx_byte <= rx_sh;
                end
                else if (rx_bit != 4'h0)
                    rx_sh <= {rx_s2, rx_sh[7:1]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame parser and replies

    always_comb
    begin
        rd_val = 12'h000;
        unique case (rx_byte[5:0])
            mcr_pkg::IDX_HEATSINK: rd_val = meas.heatsink;
            mcr_pkg::IDX_BOARD_T: rd_val = meas.board_temp;
            mcr_pkg::IDX_SUPPLY: rd_val = meas.supply;
            mcr_pkg::IDX_SPD_IN: rd_val = meas.speed_adc;
            mcr_pkg::IDX_LOAD: rd_val = meas.load_cur;
            mcr_pkg::IDX_PERIOD: rd_val = meas.period;
            mcr_pkg::IDX_PULSE: rd_val = meas.pulse_w;
            mcr_pkg::IDX_STATE: rd_val = meas.state;
            mcr_pkg::IDX_FW_REV: rd_val = meas.fw_rev;
            mcr_pkg::IDX_HW_REV: rd_val = meas.hw_rev;
            default:
                if (is_rw(rx_byte[5:0]) && rx_byte[5:0] != mcr_pkg::IDX_NODE
                    && rx_byte[5:0] != mcr_pkg::IDX_TRIM)
                    rd_val = bank[rx_byte[5:0]];
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            phase <= mcr_pkg::MCR_P_ADDR;
            cmd <= 8'h00;
            d1 <= 8'h00;
            d2 <= 8'h00;
            wr_pulse <= 1'b0;
            wr_idx <= 6'h00;
            wr_val <= 12'h000;
        end
        else if (clk_en)
        begin
            wr_pulse <= 1'b0;
            if (rx_valid)
            begin
                if (rx_byte[7])
                    phase <= (rx_byte[6:0] == node_id) ?
                        mcr_pkg::MCR_P_CMD : mcr_pkg::MCR_P_ADDR;
                else
                begin
                    unique case (phase)
                        mcr_pkg::MCR_P_ADDR: phase <= mcr_pkg::MCR_P_ADDR;
                        mcr_pkg::MCR_P_CMD:
                        begin
                            cmd <= rx_byte;
                            phase <= rx_byte[6] ? mcr_pkg::MCR_P_D1 :
                                mcr_pkg::MCR_P_CMD;
                        end
                        mcr_pkg::MCR_P_D1:
                        begin
                            d1 <= rx_byte;
                            phase <= mcr_pkg::MCR_P_D2;
                        end
                        mcr_pkg::MCR_P_D2:
                        begin
                            d2 <= rx_byte;
                            phase <= mcr_pkg::MCR_P_CRC;
                        end
                        mcr_pkg::MCR_P_CRC:
                        begin
                            phase <= mcr_pkg::MCR_P_CMD;
                            if (rx_byte[6:0] == check_of(cmd, d1, d2))
                            begin
                                wr_pulse <= is_rw(cmd[5:0]);
                                wr_idx <= cmd[5:0];
                                wr_val <= {d1[4:0], d2[6:0]};
                            end
                        end
                        default: phase <= mcr_pkg::MCR_P_ADDR;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit line

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            uart_tx <= 1'b1;
            tx_cnt <= 16'h0000;
            tx_bits <= 4'h0;
            tx_sh <= 9'h1FF;
            tx_q <= 24'h000000;
            tx_n <= 2'h0;
        end
        else if (clk_en)
        begin
            if (tx_bits == 4'h0 && tx_n != 2'h0)
            begin
                uart_tx <= 1'b0;
                tx_sh <= {1'b1, tx_q[23:16]};
                tx_q <= {tx_q[15:0], 8'h00};
                tx_n <= tx_n - 2'h1;
                tx_bits <= 4'hA;
                tx_cnt <= BIT_LEN;
            end
            else if (tx_bits != 4'h0)
            begin
                if (tx_cnt != 16'h0000)
                    tx_cnt <= tx_cnt - 16'h0001;
                else if (tx_bits == 4'h1)
                    tx_bits <= 4'h0;
                else
                begin
                    uart_tx <= tx_sh[0];
                    tx_sh <= {1'b1, tx_sh[8:1]};
                    tx_bits <= tx_bits - 4'h1;
                    tx_cnt <= BIT_LEN;
                end
            end
            if (rx_valid && !rx_byte[7])
            begin
                if (phase == mcr_pkg::MCR_P_CMD && !rx_byte[6])
                begin
                    tx_n <= 2'h3;
                    tx_q <= reply_of(rx_byte, rd_val);
                end
                else if (phase == mcr_pkg::MCR_P_CRC)
                begin
                    tx_n <= 2'h1;
                    tx_q[23:16] <= {rx_byte[6:0] != check_of(cmd, d1, d2),
                        node_id};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register store, knob tracking and speed ramp

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < 64; i++)
                bank[i] <= 12'h000;
            bank[mcr_pkg::IDX_OV_ON] <= mcr_pkg::OV_ON_RESET;
            bank[mcr_pkg::IDX_NODE] <= {5'h00, mcr_pkg::NODE_RESET};
            last_spd <= 12'h000;
            last_drive <= 12'h000;
            last_regen <= 12'h000;
            last_rise <= 12'h000;
            spd_track <= 1'b1;
            step_pre <= 10'h000;
            step_cnt <= 12'h000;
        end
        else if (clk_en)
        begin
            last_spd <= meas.speed_adc;
            last_drive <= meas.drive_knob;
            last_regen <= meas.regen_knob;
            last_rise <= meas.rise_knob;
            if (bank[mcr_pkg::IDX_HOLD][mcr_pkg::HOLD_SPEED])
                spd_track <= 1'b0;
            else if (meas.speed_adc != last_spd)
                spd_track <= 1'b1;
            if (meas.drive_knob != last_drive
                && !bank[mcr_pkg::IDX_HOLD][mcr_pkg::HOLD_DRIVE])
                bank[mcr_pkg::IDX_DRIVE] <= meas.drive_knob;
            if (meas.regen_knob != last_regen
                && !bank[mcr_pkg::IDX_HOLD][mcr_pkg::HOLD_REGEN])
                bank[mcr_pkg::IDX_REGEN] <= meas.regen_knob;
            if (meas.rise_knob != last_rise
                && !bank[mcr_pkg::IDX_HOLD][mcr_pkg::HOLD_RISE])
                bank[mcr_pkg::IDX_RISE] <= meas.rise_knob;
            step_pre <= (step_pre == STEP_LEN) ? 10'h000 :
                step_pre + 10'h001;
            if (spd_track && step_pre == STEP_LEN)
            begin
                // One code per (ramp value + 1) step periods
                if (bank[mcr_pkg::IDX_SPEED] == meas.speed_adc)
                    step_cnt <= 12'h000;
                else if (step_cnt >= ((meas.speed_adc >
                    bank[mcr_pkg::IDX_SPEED]) ? bank[mcr_pkg::IDX_RISE] :
                    bank[mcr_pkg::IDX_FALL]))
                begin
                    step_cnt <= 12'h000;
                    bank[mcr_pkg::IDX_SPEED] <= (meas.speed_adc >
                        bank[mcr_pkg::IDX_SPEED]) ?
                        bank[mcr_pkg::IDX_SPEED] + 12'h001 :
                        bank[mcr_pkg::IDX_SPEED] - 12'h001;
                end
                else
                    step_cnt <= step_cnt + 12'h001;
            end
            if (restore.valid && is_rw(restore.idx))
                bank[restore.idx] <= restore.data;
            if (wr_pulse)
            begin
                if (wr_idx == mcr_pkg::IDX_OV_OFF)
                    bank[wr_idx] <= clamp12(wr_val,
                        mcr_pkg::OV_OFF_MAX);
                else if (wr_idx == mcr_pkg::IDX_NODE)
                    bank[wr_idx] <= {5'h00, wr_val[6:0]};
                else
                    bank[wr_idx] <= wr_val;
                if (wr_idx == mcr_pkg::IDX_SPEED)
                    spd_track <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Save request and registered outputs

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            save_strobe <= 1'b0;
            save_mask <= 24'h000000;
        end
        else if (clk_en)
        begin
            save_strobe <= wr_pulse && (wr_idx == mcr_pkg::IDX_PERSIST1
                || wr_idx == mcr_pkg::IDX_PERSIST2);
            save_mask <= {bank[mcr_pkg::IDX_PERSIST2],
                bank[mcr_pkg::IDX_PERSIST1]};
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            duty_out <= 12'h000;
            drive_cap_eff <= 12'h000;
            regen_cap_eff <= 12'h000;
            settings <= '0;
        end
        else if (clk_en)
        begin
            duty_out <= cur_limit_hit ? {1'b0, duty_base[11:1]} :
                duty_base;
            drive_cap_eff <= clamp12(bank[mcr_pkg::IDX_DRIVE],
                mcr_pkg::CAP_CODE);
            regen_cap_eff <= clamp12(bank[mcr_pkg::IDX_REGEN],
                mcr_pkg::CAP_CODE);
            settings <= '{bank[mcr_pkg::IDX_RISE], bank[mcr_pkg::IDX_FALL],
                bank[mcr_pkg::IDX_UV_OFF], bank[mcr_pkg::IDX_UV_ON],
                bank[mcr_pkg::IDX_OV_ON], bank[mcr_pkg::IDX_OV_OFF],
                bank[mcr_pkg::IDX_IR_GAIN], bank[mcr_pkg::IDX_VMAX],
                bank[mcr_pkg::IDX_KNOB_LO], bank[mcr_pkg::IDX_KNOB_HI],
                bank[mcr_pkg::IDX_SETUP1], bank[mcr_pkg::IDX_SETUP2],
                bank[mcr_pkg::IDX_TRIM]};
        end
    end

    always_comb
    begin
        duty_prod = {7'h00, bank[mcr_pkg::IDX_SPEED]}
            * {12'h000, mcr_pkg::DUTY_TOP_PCT};
        duty_base = 12'(duty_prod / {12'h000, mcr_pkg::DUTY_DIV});
    end

endmodule : mcr_register_bank

// ### mcr_register_bank_chk.sv
`timescale 1ns/1ps
module mcr_register_bank_chk #(
    parameter int BIT_CYCLES = 8
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic uart_rx,
    input wire logic uart_tx,
    input wire mcr_pkg::mcr_meas_t meas,
    input wire logic cur_limit_hit,
    input wire mcr_pkg::mcr_restore_t restore,
    input wire logic [11:0] duty_out,
    input wire logic [11:0] drive_cap_eff,
    input wire logic [11:0] regen_cap_eff,
    input wire mcr_pkg::mcr_cfg_t settings,
    input wire logic save_strobe,
    input wire logic [23:0] save_mask
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////
    sequence s_start;
        $fell(uart_tx);
    endsequence
    sequence s_hit_rise;
        !cur_limit_hit ##1 cur_limit_hit;
    endsequence
    property p_duty_top;
        duty_out <= 12'hF84;
    endproperty
    property p_drive_cap;
        drive_cap_eff <= mcr_pkg::CAP_CODE;
    endproperty
    property p_regen_cap;
        regen_cap_eff <= mcr_pkg::CAP_CODE;
    endproperty
    property p_ov_off;
        settings.ov_off <= mcr_pkg::OV_OFF_MAX;
    endproperty
    property p_save_pulse;
        save_strobe |=> !save_strobe;
    endproperty
    property p_start_bit;
        s_start |-> !uart_tx [*8];
    endproperty
    property p_halve;
        s_hit_rise |=> duty_out <= ($past(duty_out) >> 1) + 12'h001;
    endproperty
    property p_ov_default;
        $rose(reset_n) |-> ##1 settings.ov_on == mcr_pkg::OV_ON_RESET;
    endproperty
    a_duty_top: assert property (p_duty_top)
        else $error("duty above top");
    a_drive_cap: assert property (p_drive_cap)
        else $error("drive cap over clamp");
    a_regen_cap: assert property (p_regen_cap)
        else $error("regen cap over clamp");
    a_ov_off: assert property (p_ov_off)
        else $error("ov off over clamp");
    a_save_pulse: assert property (p_save_pulse)
        else $error("save strobe too long");
    a_start_bit: assert property (p_start_bit)
        else $error("short start bit");
    a_halve: assert property (p_halve)
        else $error("duty not halved");
    a_ov_default: assert property (p_ov_default)
        else $error("ov on default wrong");
endmodule : mcr_register_bank_chk

bind mcr_register_bank mcr_register_bank_chk #(.BIT_CYCLES(BIT_CYCLES)) u_chk (
    .ref_clk, .reset_n, .clk_en, .uart_rx, .uart_tx, .meas, .cur_limit_hit,
    .restore, .duty_out, .drive_cap_eff, .regen_cap_eff, .settings,
    .save_strobe, .save_mask
);

// ### mcr_host.sv
`timescale 1ns/1ps
module mcr_host #(
    parameter int BIT = 8
) (
    input wire logic ref_clk,
    input wire logic dev_tx,
    output logic host_tx
);
    logic [7:0] rxq[$];
    initial host_tx = 1'b1;
    ////////////////////////////////////////////////////////////////////////
    task automatic put_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            host_tx <= f[i];
            repeat (BIT) @(posedge ref_clk);
        end
    endtask : put_byte
    task automatic write_frame(input logic [7:0] cmd, input logic [11:0] v,
        input logic bad);
        logic [7:0] d1;
        logic [7:0] d2;
        d1 = {3'b000, v[11:7]};
        d2 = {1'b0, v[6:0]};
        put_byte(8'h80);
        put_byte(cmd);
        put_byte(d1);
        put_byte(d2);
        put_byte({1'b0, (cmd[6:0] + d1[6:0] + d2[6:0]) ^ {6'h00, bad}});
    endtask : write_frame
    task automatic read_frame(input logic [7:0] cmd);
        put_byte(8'h80);
        put_byte(cmd);
    endtask : read_frame
    task automatic get_byte(output logic [7:0] b, output logic ok);
        ok = 1'b0;
        b = 8'h00;
        for (int i = 0; i < 200 * BIT && !ok; i++)
        begin
            if (rxq.size() != 0)
            begin
                b = rxq.pop_front();
                ok = 1'b1;
            end
            else
                @(posedge ref_clk);
        end
    endtask : get_byte
    ////////////////////////////////////////////////////////////////////////
    // Mid-bit sampling receiver
    initial
    begin
        logic [7:0] b;
        forever
        begin
            @(negedge dev_tx);
            repeat (BIT / 2) @(posedge ref_clk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT) @(posedge ref_clk);
                b[i] = dev_tx;
            end
            repeat (BIT) @(posedge ref_clk);
            rxq.push_back(b);
        end
    end
endmodule : mcr_host

// ### motor_ctrl_uart_register_bank_test.sv
`timescale 1ns/1ps
module motor_ctrl_uart_register_bank_test;
    logic ref_clk;
    logic reset_n;
    logic uart_rx;
    logic uart_tx;
    logic cur_limit_hit;
    mcr_pkg::mcr_meas_t meas;
    mcr_pkg::mcr_restore_t restore;
    mcr_pkg::mcr_cfg_t settings;
    logic [11:0] duty_out;
    logic [11:0] drive_cap_eff;
    logic [11:0] regen_cap_eff;
    logic save_strobe;
    logic [23:0] save_mask;
    int num_errors;
    int n_compared;
    int saves;
    int exp_reg[64];
    logic [7:0] r0;
    logic [7:0] r1;
    logic [7:0] r2;
    logic ok;
    logic [7:0] wcmds[12] = '{8'h40, 8'h42, 8'h43, 8'h44, 8'h46, 8'h47,
        8'h48, 8'h49, 8'h60, 8'h61, 8'h74, 8'h75};

    mcr_register_bank #(.BIT_CYCLES(8)) dut (.ref_clk(ref_clk),
        .reset_n(reset_n), .clk_en(1'b1), .uart_rx(uart_rx),
        .uart_tx(uart_tx), .meas(meas), .cur_limit_hit(cur_limit_hit),
        .restore(restore), .duty_out(duty_out),
        .drive_cap_eff(drive_cap_eff), .regen_cap_eff(regen_cap_eff),
        .settings(settings), .save_strobe(save_strobe),
        .save_mask(save_mask));
    mcr_host #(.BIT(8)) host (.ref_clk(ref_clk), .dev_tx(uart_tx),
        .host_tx(uart_rx));
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (num_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test
    task automatic check(input string what, input logic [11:0] exp,
        input logic [11:0] got);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask : check
    task automatic reply(output logic [7:0] b);
        host.get_byte(b, ok);
        if (!ok)
        begin
            num_errors++;
            stop_test();
        end
    endtask : reply
    task automatic wr(input logic [7:0] cmd, input logic [11:0] v,
        input logic bad);
        host.write_frame(cmd, v, bad);
        reply(r0);
        check("ack", {4'h0, bad, 7'h00}, {4'h0, r0});
        if (!bad && cmd < 8'h7C)
            exp_reg[cmd[5:0]] = (cmd == 8'h49 && v > 12'hA8D) ? 12'hA8D : v;
    endtask : wr
    task automatic rd(input logic [7:0] cmd);
        host.read_frame(cmd);
        reply(r0);
        reply(r1);
        reply(r2);
        check("rd_val", 12'(exp_reg[cmd[5:0]]), {r0[4:0], r1[6:0]});
        check("rd_pad", 12'h000, {7'h00, r0[7:5], r1[7], r2[7]});
        check("rd_chk", {5'h00, cmd[6:0] + r0[6:0] + r1[6:0]},
            {5'h00, r2[6:0]});
    endtask : rd
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
        if (save_strobe === 1'b1)
            saves++;
    initial
    begin
        void'($urandom(32'h15791FD5));
        num_errors = 0;
        n_compared = 0;
        saves = 0;
        reset_n = 1'b0;
        cur_limit_hit = 1'b0;
        meas = '0;
        restore = '0;
        foreach (exp_reg[i])
            exp_reg[i] = 0;
        exp_reg[8] = 12'hA28;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(8'h08);
        rd(8'h0F);
        foreach (wcmds[i])
        begin
            wr(wcmds[i], 12'($urandom), 1'b0);
            rd(wcmds[i] & 8'h3F);
        end
        wr(8'h40, 12'hFFF, 1'b0);
        check("duty_top", 12'hF84, duty_out);
        cur_limit_hit <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("duty_half", 12'h7C2, duty_out);
        cur_limit_hit <= 1'b0;
        wr(8'h42, 12'hFFF, 1'b0);
        wr(8'h43, 12'hFFF, 1'b0);
        wr(8'h49, 12'hFFF, 1'b0);
        check("drive_cap", 12'hE55, drive_cap_eff);
        check("regen_cap", 12'hE55, regen_cap_eff);
        rd(8'h09);
        wr(8'h40, 12'h123, 1'b1);
        rd(8'h00);
        wr(8'h44, 12'h000, 1'b0);
        wr(8'h45, 12'h000, 1'b0);
        meas.speed_adc <= 12'hFFD;
        repeat (2500) @(posedge ref_clk);
        exp_reg[0] = 12'hFFD;
        rd(8'h00);
        wr(8'h71, 12'h003, 1'b0);
        meas.speed_adc <= 12'hF00;
        meas.drive_knob <= 12'h555;
        repeat (2500) @(posedge ref_clk);
        rd(8'h00);
        rd(8'h02);
        wr(8'h71, 12'h000, 1'b0);
        meas.drive_knob <= 12'h556;
        repeat (5) @(posedge ref_clk);
        exp_reg[2] = 12'h556;
        rd(8'h02);
        rd(8'h00);
        wr(8'h72, 12'h5A3, 1'b0);
        check("saves", 12'h001, 12'(saves));
        check("save_mask", 12'h5A3, save_mask[11:0]);
        restore <= '{valid: 1'b1, idx: mcr_pkg::IDX_FALL, data: 12'h2A5};
        @(posedge ref_clk);
        restore <= '0;
        repeat (3) @(posedge ref_clk);
        check("restore", 12'h2A5, settings.fall);
        wr(8'h7D, 12'h3C6, 1'b0);
        check("trim", 12'h3C6, settings.trim);
        rd(8'h3D);
        stop_test();
    end
endmodule : motor_ctrl_uart_register_bank_test
